/* File: pas_pkg.sv */
/*
  Shared constants for the program address sequencer: sizes, APB
  register offsets, field positions, reset values and operation codes.
  Assumes a 32-bit APB register bus with byte addresses.
*/
`default_nettype none

package pas_pkg;

  // memory geometry
  localparam int unsigned WORD_W     = 6;   // word within a page
  localparam int unsigned PAGE_W     = 4;   // page number
  localparam int unsigned ROM_WORDS  = 1024;
  localparam int unsigned ROM_PAGES  = 16;
  localparam int unsigned STACK_DEP  = 2;   // return stack levels
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned RAM_WORDS  = 32;
  localparam int unsigned RAM_AW     = 5;
  localparam int unsigned DEPTH_W    = 2;
  localparam int unsigned PTR_W      = 6;   // bank ptr [5:4], word ptr [3:0]

  // machine cycle: clocks per instruction slot
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam logic [2:0]  MC_LAST    = 3'h5;  // six clocks, 0..5
  localparam logic [2:0]  MC_FIRST   = 3'h0;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_INSTR   = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_PTR     = 8'h0C;
  localparam logic [7:0] OFF_DATA    = 8'h10;
  localparam logic [7:0] OFF_ADDR    = 8'h14;
  localparam logic [7:0] OFF_STACK   = 8'h18;

  // field positions
  localparam int unsigned CTRL_RUN    = 0;
  localparam int unsigned INSTR_OP_LSB  = 0;
  localparam int unsigned INSTR_ARG_LSB = 4;
  localparam int unsigned ST_PEND     = 0;
  localparam int unsigned ST_DEPTH    = 1;
  localparam int unsigned ST_MRST     = 3;
  localparam int unsigned ST_BUF      = 4;
  localparam int unsigned ADDR_PAGE   = 6;
  localparam int unsigned STK_ENT1    = 16;
  localparam int unsigned PTR_BANK0   = 4;

  // reset values
  localparam logic [WORD_W-1:0] WORD_RST = 6'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 4'h0;

  // operations issued through the instruction register
  typedef enum logic [2:0] {
    OP_ADVANCE                    = 3'h0,
    OP_LOAD_BANK_BUFFER_IMMEDIATE = 3'h1,
    OP_JUMP                       = 3'h2,
    OP_CALL                       = 3'h3,
    OP_SUBROUTINE_RETURN          = 3'h4
  } pas_op_t;

endpackage : pas_pkg

`default_nettype wire

/* File: pas_sequencer.sv */
/*
  Program address sequencer with an APB register slave: word counter,
  bank select, bank buffer, two-level return stack, data-memory
  pointers and a 32-nibble data memory.
  Assumes an APB master on pclk and a manual reset pin from outside
  the clock domain.

*/
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module pas_sequencer
  import pas_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // manual reset pin, active low, asynchronous
  input  wire logic                manual_reset_n,
  // program memory address and fetch strobe
  output logic      [WORD_W-1:0]   rom_word_counter,
  output logic      [PAGE_W-1:0]   rom_bank_select,
  output logic                     fetch_pulse,
  // data memory address
  output logic      [RAM_AW-1:0]   data_addr
);

  // ---------------------------------------------------------------
  // state
  logic [2:0]          phase_q;
  logic [WORD_W-1:0]   word_q;
  logic [PAGE_W-1:0]   page_q;
  logic [PAGE_W-1:0]   buf_q;         // rom_bank_buffer
  logic [WORD_W-1:0]   stk_word_q [STACK_DEP];
  logic [PAGE_W-1:0]   stk_page_q [STACK_DEP];
  logic [DEPTH_W-1:0]  depth_q;
  logic                run_q;
  logic                pend_q;
  pas_op_t             op_q;
  logic [WORD_W-1:0]   arg_q;
  logic [PTR_W-1:0]    ptr_q;
  logic [NIB_W-1:0]    ram [RAM_WORDS];
  logic                mrst_s1_q;
  logic                mrst_s2_q;
  logic                fetch_q;
  logic [RAM_AW-1:0]   daddr_q;
  logic                pready_q;
  logic                pslverr_q;
  logic [31:0]         prdata_q;

  // decoded strobes
  logic                boundary;
  logic                exec;
  logic                acc_req;
  logic                commit;
  logic                wr_commit;
  logic                sel_ok;
  logic                stall;
  logic [31:0]         rd_data;
  logic [RAM_AW-1:0]   ram_idx;

  // ---------------------------------------------------------------
  // manual reset pin synchroniser, two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrst_s1_q <= 1'b0;
      mrst_s2_q <= 1'b0;
    end else begin
      mrst_s1_q <= manual_reset_n;
      mrst_s2_q <= mrst_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // machine-cycle phase counter
  // six-clock slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= MC_FIRST;
    end else if (!mrst_s2_q || !run_q) begin
      phase_q <= MC_FIRST;
    end else if (phase_q == MC_LAST) begin
      phase_q <= MC_FIRST;
    end else begin
      phase_q <= phase_q + 3'h1;
    end
  end

  // one fetch per machine cycle; a pending operation executes with it
  assign boundary = run_q && mrst_s2_q && (phase_q == MC_LAST);
  assign exec     = boundary && pend_q;

  // ---------------------------------------------------------------
  // word counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= WORD_RST;
    end else if (!mrst_s2_q) begin
      word_q <= WORD_RST;
    end else if (boundary) begin
      if (exec && (op_q == OP_JUMP || op_q == OP_CALL)) begin
        word_q <= arg_q;
      end else if (exec && op_q == OP_SUBROUTINE_RETURN) begin
        word_q <= stk_word_q[0];
      end else begin
        word_q <= word_q + 6'h01;   // wraps inside the page
      end
    end
  end

  // ---------------------------------------------------------------
  // bank select, only page-changing operations touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= PAGE_RST;
    end else if (!mrst_s2_q) begin
      page_q <= PAGE_RST;
    end else if (exec) begin
      case (op_q)
        OP_JUMP,
        OP_CALL:              page_q <= buf_q;
        OP_SUBROUTINE_RETURN: page_q <= stk_page_q[0];
        default:              page_q <= page_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bank buffer, staged for the next jump or call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q <= PAGE_RST;
    end else if (exec && op_q == OP_LOAD_BANK_BUFFER_IMMEDIATE) begin
      buf_q <= arg_q[PAGE_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // return stack, entry 0 is the top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STACK_DEP; i++) begin
        stk_word_q[i] <= WORD_RST;
        stk_page_q[i] <= PAGE_RST;
      end
    end else if (exec && op_q == OP_CALL) begin
      stk_word_q[0] <= word_q + 6'h01;
      stk_page_q[0] <= page_q;
      for (int i = 1; i < STACK_DEP; i++) begin
        stk_word_q[i] <= stk_word_q[i-1];
        stk_page_q[i] <= stk_page_q[i-1];
      end
    end else if (exec && op_q == OP_SUBROUTINE_RETURN) begin
      for (int i = 0; i < STACK_DEP - 1; i++) begin
        stk_word_q[i] <= stk_word_q[i+1];
        stk_page_q[i] <= stk_page_q[i+1];
      end
      stk_word_q[STACK_DEP-1] <= WORD_RST;
      stk_page_q[STACK_DEP-1] <= PAGE_RST;
    end
  end

  // stack fill level, saturating; deeper calls drop the oldest entry
  // two levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_q <= 2'h0;
    end else if (exec && op_q == OP_CALL) begin
      if (depth_q != 2'(STACK_DEP)) begin
        depth_q <= depth_q + 2'h1;
      end
    end else if (exec && op_q == OP_SUBROUTINE_RETURN) begin
      if (depth_q != 2'h0) begin
        depth_q <= depth_q - 2'h1;
      end
    end
  end

  // fetch strobe, one clock per fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= boundary;
    end
  end

  // ---------------------------------------------------------------
  // apb decode; an instruction write waits while one is pending
  assign acc_req  = psel && penable && !pready_q;
  assign commit   = psel && penable && pready_q;
  assign wr_commit = commit && pwrite && !pslverr_q;
  assign stall    = pwrite && (paddr == OFF_INSTR) && pend_q;

  always_comb begin
    sel_ok = 1'b1;
    case (paddr)
      OFF_CTRL, OFF_INSTR, OFF_STATUS, OFF_PTR,
      OFF_DATA, OFF_ADDR, OFF_STACK: sel_ok = 1'b1;
      default:                       sel_ok = 1'b0;
    endcase
  end

  // bank bit zero and word pointer
  assign ram_idx = {ptr_q[PTR_BANK0], ptr_q[NIB_W-1:0]};

  // read mux, unused bits read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (paddr)
      OFF_CTRL:   rd_data[CTRL_RUN] = run_q;
      OFF_INSTR: begin
        rd_data[INSTR_OP_LSB +: 3]       = op_q;
        rd_data[INSTR_ARG_LSB +: WORD_W] = arg_q;
      end
      OFF_STATUS: begin
        rd_data[ST_PEND]             = pend_q;
        rd_data[ST_DEPTH +: DEPTH_W] = depth_q;
        rd_data[ST_MRST]             = !mrst_s2_q;
        rd_data[ST_BUF +: PAGE_W]    = buf_q;
      end
      OFF_PTR:    rd_data[PTR_W-1:0] = ptr_q;
      OFF_DATA:   rd_data[NIB_W-1:0] = ram[ram_idx];
      OFF_ADDR: begin
        rd_data[WORD_W-1:0]           = word_q;
        rd_data[ADDR_PAGE +: PAGE_W]  = page_q;
      end
      OFF_STACK: begin
        rd_data[WORD_W-1:0]                   = stk_word_q[0];
        rd_data[ADDR_PAGE +: PAGE_W]          = stk_page_q[0];
        rd_data[STK_ENT1 +: WORD_W]           = stk_word_q[1];
        rd_data[STK_ENT1+ADDR_PAGE +: PAGE_W] = stk_page_q[1];
      end
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  // ready, error and read data registered one clock into the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (commit) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (acc_req && !stall) begin
      pready_q  <= 1'b1;
      pslverr_q <= !sel_ok;
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  // ---------------------------------------------------------------
  // control and pointer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q   <= 1'b0;
      ptr_q   <= '0;
      daddr_q <= '0;
    end else if (wr_commit) begin
      if (paddr == OFF_CTRL) begin
        run_q <= pwdata[CTRL_RUN];
      end
      if (paddr == OFF_PTR) begin
        ptr_q   <= pwdata[PTR_W-1:0];
        daddr_q <= {pwdata[PTR_BANK0], pwdata[NIB_W-1:0]};
      end
    end
  end

  // instruction register and pending flag; a new write wins a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      op_q   <= OP_ADVANCE;
      arg_q  <= '0;
    end else if (wr_commit && paddr == OFF_INSTR) begin
      pend_q <= 1'b1;
      op_q   <= pas_op_t'(pwdata[INSTR_OP_LSB +: 3]);
      arg_q  <= pwdata[INSTR_ARG_LSB +: WORD_W];
    end else if (exec) begin
      pend_q <= 1'b0;
    end
  end

  // data memory, reached only through the pointers
  // pointer access
  always_ff @(posedge pclk) begin
    if (wr_commit && paddr == OFF_DATA) begin
      ram[ram_idx] <= pwdata[NIB_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ten-bit program address
  assign rom_word_counter = word_q;
  assign rom_bank_select  = page_q;
  assign fetch_pulse      = fetch_q;
  assign data_addr        = daddr_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign prdata           = prdata_q;

endmodule : pas_sequencer

`default_nettype wire

/* File: pas_rom_model.sv */
/*
  Program ROM model facing the address sequencer outputs.
  Assumes word and page come straight from the sequencer flops.
*/
`timescale 1ns/1ns
`default_nettype none

module pas_rom_model
  import pas_pkg::*;
(
  // address in
  input  wire logic [WORD_W-1:0] word,
  input  wire logic [PAGE_W-1:0] page,
  // instruction byte out
  output logic      [7:0]        rom_byte
);
  logic [7:0] rom_q [ROM_WORDS];

  // fill with a pattern from the low eight address bits; pages four apart repeat
  initial begin
    for (int i = 0; i < ROM_WORDS; i++) begin
      rom_q[i] = 8'(i) ^ 8'hA5;
    end
  end

  // byte at {page, word}
  assign rom_byte = rom_q[{page, word}];
endmodule : pas_rom_model

`default_nettype wire

/* File: pas_sequencer_chk.sv */
/*
  Port checker for the program address sequencer.
  Assumes it is bound to pas_sequencer and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none

module pas_chk
  import pas_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // sequencer side
  input wire logic              manual_reset_n,
  input wire logic [WORD_W-1:0] rom_word_counter,
  input wire logic [PAGE_W-1:0] rom_bank_select,
  input wire logic              fetch_pulse,
  input wire logic [RAM_AW-1:0] data_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // write data seen one edge earlier
  logic [31:0] wd_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_q <= 32'h0;
    else wd_q <= pwdata;
  end

  property p_rst_zero;
    $rose(presetn) |-> rom_word_counter == WORD_RST &&
      rom_bank_select == PAGE_RST;
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("address not zero after reset");

  property p_word_hold;
    manual_reset_n [*4] ##0 $changed(rom_word_counter) |-> fetch_pulse;
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("word moved without a fetch");

  property p_page_hold;
    manual_reset_n [*4] ##0 $changed(rom_bank_select) |-> fetch_pulse;
  endproperty
  a_page_hold: assert property (p_page_hold)
    else $error("page moved without a fetch");

  property p_fetch_gap;
    fetch_pulse |=> !fetch_pulse [*5];
  endproperty
  a_fetch_gap: assert property (p_fetch_gap)
    else $error("fetches closer than six clocks");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");

  property p_ready_wait;
    psel && penable && !pready && !(pwrite && paddr == OFF_INSTR)
      |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("ready late");

  property p_slverr;
    pready && psel && paddr > OFF_STACK |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not refused");

  property p_manual;
    !manual_reset_n [*4] |-> rom_word_counter == WORD_RST &&
      rom_bank_select == PAGE_RST;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual reset did not clear address");

  property p_ptr;
    pready && psel && pwrite && paddr == OFF_PTR && !pslverr
      |=> data_addr == {wd_q[PTR_BANK0], wd_q[NIB_W-1:0]};
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("data address not from pointers");
endmodule : pas_chk

bind pas_sequencer pas_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .manual_reset_n(manual_reset_n),
  .rom_word_counter(rom_word_counter), .rom_bank_select(rom_bank_select),
  .fetch_pulse(fetch_pulse), .data_addr(data_addr)
);

`default_nettype wire

/* File: tb_top.sv */
/*
  Testbench for the program address sequencer: APB tasks, an address
  model and sequences of operations.
  Assumes operations written back to back each execute at one fetch.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import pas_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, er;
  logic              manual_reset_n, fetch_pulse, pready, pslverr;
  logic [7:0]        paddr, rom_byte;
  logic [31:0]       pwdata, prdata, rd;
  logic [WORD_W-1:0] rom_word_counter, w;
  logic [PAGE_W-1:0] rom_bank_select, p, b;
  logic [RAM_AW-1:0] data_addr;
  logic [9:0]        s0, s1;
  int                mismatches, checked;

  // device and program memory
  pas_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .manual_reset_n(manual_reset_n), .rom_word_counter(rom_word_counter),
    .rom_bank_select(rom_bank_select), .fetch_pulse(fetch_pulse),
    .data_addr(data_addr));
  pas_rom_model u_rom (.word(rom_word_counter), .page(rom_bank_select),
    .rom_byte(rom_byte));

  // 50 ns clock
  always #25 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] ex, got);
    checked++;
    if (got !== ex) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // one apb transfer, then one idle edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  // issue an operation and update the expected address state
  task automatic op(input logic [2:0] o, input logic [5:0] a);
    apb(1'h1, OFF_INSTR, {22'h0, a, 1'h0, o});
    if (o == 3'h4) begin
      {p, w} = s0;
      s0 = s1;
      s1 = '0;
    end else if (o >= 3'h2) begin
      if (o == 3'h3) begin
        s1 = s0;
        s0 = {p, w + 6'h01};
      end
      w = a;
      p = b;
    end else begin
      if (o == 3'h1) b = a[3:0];
      w = w + 6'h01;
    end
  endtask : op

  // queue an advance, read the address before it executes
  task automatic look(input string nm);
    apb(1'h1, OFF_INSTR, 32'h0);
    apb(1'h0, OFF_ADDR, 32'h0);
    chk(nm, {22'h0, p, w}, rd);
    w = w + 6'h01;
    // the queued advance has run; rom byte follows the new address
    chk("rom byte", {24'h0, 8'({p, w}) ^ 8'hA5}, {24'h0, rom_byte});
  endtask : look

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_of_test;
  end

  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    manual_reset_n = 1'h1;
    {w, p, b, s0, s1} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, OFF_ADDR, 32'h0);
    chk("addr", 32'h0, rd);
    apb(1'h0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'h1, OFF_PTR, 32'h1A);
    chk("daddr", 32'h1A, {27'h0, data_addr});
    apb(1'h1, OFF_DATA, 32'h7);
    apb(1'h1, OFF_PTR, 32'h0A);
    apb(1'h1, OFF_DATA, 32'h3);
    apb(1'h1, OFF_PTR, 32'h1A);
    apb(1'h0, OFF_DATA, 32'h0);
    chk("nibble", 32'h7, rd);
    op(OP_ADVANCE, 6'h00);
    apb(1'h1, OFF_CTRL, 32'h1);
    op(OP_ADVANCE, 6'h00);
    look("count");
    op(OP_LOAD_BANK_BUFFER_IMMEDIATE, 6'h05);
    look("buffer");
    op(OP_JUMP, 6'h3E);
    look("jump");
    op(OP_ADVANCE, 6'h00);
    look("wrap");
    op(OP_LOAD_BANK_BUFFER_IMMEDIATE, 6'h09);
    op(OP_CALL, 6'h10);
    op(OP_LOAD_BANK_BUFFER_IMMEDIATE, 6'h02);
    op(OP_CALL, 6'h20);
    look("call");
    apb(1'h0, OFF_STACK, 32'h0);
    chk("stack", {6'h0, s1, 6'h0, s0}, rd);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk("status", 32'h24, rd & 32'hFE);
    op(OP_SUBROUTINE_RETURN, 6'h00);
    look("ret1");
    op(OP_SUBROUTINE_RETURN, 6'h00);
    look("ret2");
    apb(1'h0, OFF_STACK, 32'h0);
    chk("stack pop", {6'h0, s1, 6'h0, s0}, rd);
    manual_reset_n <= 1'h0;
    repeat (6) @(posedge pclk);
    apb(1'h0, OFF_ADDR, 32'h0);
    chk("mreset", 32'h0, rd);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk("mreset flag", 32'h1 << ST_MRST, rd & (32'h1 << ST_MRST));
    manual_reset_n <= 1'h1;
    repeat (4) @(posedge pclk);
    end_of_test;
  end
endmodule : tb_top

`default_nettype wire
